// *** src/dasp_port.sv ***
// Purpose: serial readout and register port of a dual sampling converter
// Assumes: cs_n, sclk, sdi come from the host; conversion data comes from core logic
// Notes: link side on sclk and cs_n; control side on ref_clk
// Behaviour
// R1: self test runs after reset or hard reset
// R2: failed self test sets setup_fail_flag
// R3: chip select fall samples and enables outputs
// R4: host gives at least sixteen clocks per access
// R5: conversion timed by ref_clk, not sclk
// R6: results of a conversion read next frame
// R7: msb out at cs fall, rest on sclk
// R8: cs rise returns outputs to high impedance
// R9: host finishes access in one cs low period
// R10: two-lane frame lengths 16/18/24/26
// R11: lane select 0 gives two-lane output
// R12: one-lane sends A then B, 32..44 clocks
// R13: boost with oversampling gives 18-bit results
// R14: second cs after conversion reads same result
// R15: read command returns register next frame
// R16: write command carries address and 12 data bits
// R17: write frame 16 or 24 bits by crc
// R18: read and write crc enabled separately
// R19: read crc appended on output_a
// R20: read crc in every lane and boost mode
// R21: enabling write crc needs valid crc
// R22: with write crc, bad-crc writes ignored
// R23: crc polynomial x^8+x^2+x+1
// R24: crc data top byte inverted, zero extended
// R25: unlisted addresses are no-operations
`timescale 1ns/1ps
module dasp_port
  import dasp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic [17:0] conv_a,
  input wire logic [17:0] conv_b,
  input wire logic selftest_ok,
  output logic output_a,
  output logic output_a_oe,
  output logic output_b_alert,
  output logic output_b_alert_oe,
  output logic conv_start,
  output logic conv_busy,
  output logic setup_fail_flag,
  output logic [11:0] config_word_one,
  output logic [11:0] config_word_two
);
  // ---------------- control domain (ref_clk) ----------------
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic [11:0] cfg1_q;
  logic [11:0] cfg2_q;
  logic [8:0] conv_cnt_q;
  logic [17:0] res_a_q;
  logic [17:0] res_b_q;
  logic [4:0] st_cnt_q;
  logic st_busy_q;
  logic fail_q;
  // toggle synchroniser plus two stages: word is captured one cycle before it is decoded
  logic ev_tg_s1_q;
  logic ev_tg_s2_q;
  logic ev_tg_s3_q;
  logic ev_tg_s4_q;
  logic [35:0] ev_word_q;
  logic [2:0] rd_addr_q;
  logic rd_pend_q;

  // ---------------- link domain (sclk fall and rise, cs_n rise; counter and shifter reset by cs_n high) ----------------
  logic [5:0] bit_cnt_q;
  logic [23:0] rx_q;
  logic ev_tg_q;
  logic [35:0] ev_hold_q;

  wire cs_fall = cs_s3_q & ~cs_s2_q;
  wire cs_rise = ~cs_s3_q & cs_s2_q;
  wire ev_seen = ev_tg_s4_q ^ ev_tg_s3_q;
  wire osr_on = |cfg1_q[CFG1_OSR_LSB +: 3];
  wire boost = cfg1_q[CFG1_RES] & osr_on; // see R13
  wire rcrc = cfg1_q[CFG1_RCRC]; // see R18
  wire wcrc = cfg1_q[CFG1_WCRC]; // see R18
  wire one_lane = cfg2_q[CFG2_LANE]; // see R11

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      ev_tg_s1_q <= 1'b0;
      ev_tg_s2_q <= 1'b0;
      ev_tg_s3_q <= 1'b0;
      ev_tg_s4_q <= 1'b0;
    end else begin
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      ev_tg_s1_q <= ev_tg_q;
      ev_tg_s2_q <= ev_tg_s1_q;
      ev_tg_s3_q <= ev_tg_s2_q;
      ev_tg_s4_q <= ev_tg_s3_q;
    end
  end

  // command word decoded in control domain after cs rise
  logic [23:0] cmd;
  logic [5:0] cmd_len;
  assign cmd = ev_word_q[23:0];
  assign cmd_len = ev_word_q[29:24];
  // the frame length, not the current mode, says where the command sits in the shifter
  wire long_frame = cmd_len == 6'(CMD_CRC_BITS);
  wire [15:0] cmd16 = long_frame ? cmd[23:8] : cmd[15:0];
  wire is_write = cmd_len >= 6'(CMD_BITS) && cmd16[15];
  wire is_read = cmd_len >= 6'(CMD_BITS) && !cmd16[15]; // see R4
  wire [2:0] cmd_addr = cmd16[14:12]; // see R15 R16
  wire [11:0] cmd_data = cmd16[11:0];
  logic [7:0] wr_crc;
  dasp_crc8 u_wcrc (
    .data({20'h00000, cmd[23:8]}),
    .nbits(6'd16),
    .crc(wr_crc)
  );
  wire wr_crc_ok = wr_crc == cmd[7:0];
  wire new_wcrc = cmd_data[CFG1_WCRC];
  // crc needed if currently on, or the write turns it on
  wire need_crc = wcrc | (cmd_addr == ADDR_CFG1 && new_wcrc); // see R21 R22
  // a 16-bit frame carries no checksum, so it can never pass the gate
  wire crc_good = long_frame & wr_crc_ok; // see R17
  wire wr_ok = ev_seen & is_write & (!need_crc | crc_good);
  wire wr_cfg1 = wr_ok && cmd_addr == ADDR_CFG1;
  wire wr_cfg2 = wr_ok && cmd_addr == ADDR_CFG2; // see R25
  wire hard_rst = wr_cfg2 && cmd_data[CFG2_RST_LSB +: 2] == RST_HARD;
  wire rd_valid = cmd_addr == ADDR_CFG1 || cmd_addr == ADDR_CFG2 || cmd_addr == ADDR_STAT;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg1_q <= CFG1_RESET;
      cfg2_q <= CFG2_RESET;
      rd_pend_q <= 1'b0;
      rd_addr_q <= 3'h0;
    end else if (hard_rst) begin
      cfg1_q <= CFG1_RESET;
      cfg2_q <= CFG2_RESET;
      rd_pend_q <= 1'b0;
    end else begin
      if (wr_cfg1) begin
        cfg1_q <= cmd_data;
      end
      if (wr_cfg2) begin
        cfg2_q <= {4'h0, cmd_data[7:0]};
      end
      if (ev_seen) begin
        rd_pend_q <= is_read & rd_valid; // see R15 R25
        rd_addr_q <= cmd_addr;
      end
    end
  end

  // self test: runs after reset release and after hard reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_busy_q <= 1'b1;
      st_cnt_q <= 5'h00;
      fail_q <= 1'b0;
    end else if (hard_rst) begin
      st_busy_q <= 1'b1; // see R1
      st_cnt_q <= 5'h00;
      fail_q <= 1'b0;
    end else if (st_busy_q) begin
      st_cnt_q <= st_cnt_q + 5'h01;
      if (st_cnt_q == 5'(SELFTEST_CYCLES - 1)) begin
        st_busy_q <= 1'b0;
        fail_q <= ~selftest_ok; // see R2
      end
    end
  end

  // conversion timer on ref_clk only; sclk plays no part
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_cnt_q <= 9'h000;
      res_a_q <= 18'h00000;
      res_b_q <= 18'h00000;
    end else if (cs_fall) begin
      conv_cnt_q <= 9'(CONV_CYCLES); // see R3 R5 R6
    end else if (conv_cnt_q != 9'h000) begin
      conv_cnt_q <= conv_cnt_q - 9'h001;
      if (conv_cnt_q == 9'h001) begin
        res_a_q <= conv_a; // see R14
        res_b_q <= conv_b;
      end
    end
  end

  assign conv_start = cs_fall;
  assign conv_busy = conv_cnt_q != 9'h000;
  assign setup_fail_flag = fail_q;
  assign config_word_one = cfg1_q;
  assign config_word_two = cfg2_q;

  // outgoing frame image, built in control domain and held stable while cs low
  typedef enum logic [2:0] {
    FR_REG,
    FR_TWO,
    FR_TWO_BOOST,
    FR_ONE,
    FR_ONE_BOOST
  } dasp_frame_e;

  dasp_frame_e frame_kind;
  logic [SHIFT_W-1:0] img_a;
  logic [SHIFT_W-1:0] img_b;
  logic [SHIFT_W-1:0] img_a_q;
  logic [SHIFT_W-1:0] img_b_q;
  logic [5:0] dlen;
  logic [7:0] out_crc;
  logic [11:0] reg_val;
  assign reg_val = rd_addr_q == ADDR_CFG1 ? cfg1_q :
                   rd_addr_q == ADDR_CFG2 ? cfg2_q : {11'h000, fail_q};
  wire [15:0] a16 = res_a_q[17:2];
  wire [15:0] b16 = res_b_q[17:2];
  wire [35:0] crc_in = rd_pend_q ? {20'h00000, ~{1'b0, rd_addr_q, reg_val[11:8]}, reg_val[7:0]} :
                       boost ? {~res_a_q[17:10], res_a_q[9:0], res_b_q} :
                       {4'h0, ~a16[15:8], a16[7:0], b16}; // see R24
  wire [5:0] crc_len = rd_pend_q ? 6'd16 : (boost ? 6'd36 : 6'd32);
  dasp_crc8 u_rcrc (
    .data(crc_in),
    .nbits(crc_len),
    .crc(out_crc)
  ); // see R23 R19


  // a pending register read takes the next frame over from conversion data
  assign frame_kind = rd_pend_q ? FR_REG :
                      one_lane ? (boost ? FR_ONE_BOOST : FR_ONE) :
                      (boost ? FR_TWO_BOOST : FR_TWO);

  always_comb begin
    img_a = '0;
    img_b = '0;
    dlen = 6'd16;
    unique case (frame_kind)
      FR_REG: begin
        img_a[43:28] = {1'b0, rd_addr_q, reg_val}; // see R15
        dlen = 6'd16;
      end
      FR_ONE: begin
        img_a[43:12] = {a16, b16}; // see R12
        dlen = 6'd32;
      end
      FR_ONE_BOOST: begin
        img_a[43:8] = {res_a_q, res_b_q}; // see R12 R13
        dlen = 6'd36;
      end
      FR_TWO: begin
        img_a[43:28] = a16; // see R11
        img_b[43:28] = b16;
        dlen = 6'd16;
      end
      FR_TWO_BOOST: begin
        img_a[43:26] = res_a_q; // see R10 R11 R13
        img_b[43:26] = res_b_q;
        dlen = 6'd18;
      end
    endcase
    // checksum follows the last data bit on output_a; 44 bits cover the longest frame
    if (rcrc) begin // see R19 R20
      img_a = img_a | ({out_crc, 36'h0} >> dlen);
    end
  end

  // reload only while cs has been high for two samples; a load just after a
  // cs fall rewrites the same value, since nothing it depends on moves in a frame
  wire img_load = cs_s2_q & cs_s3_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      img_a_q <= '0;
      img_b_q <= '0;
    end else if (img_load) begin
      img_a_q <= img_a;
      img_b_q <= img_b;
    end
  end

  // ---------------- link domain ----------------
  // image is frozen after cs_n falls: control side only updates it well apart from frame edges
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q <= 6'h00;
    end else begin
      bit_cnt_q <= bit_cnt_q + 6'h01; // see R7
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rx_q <= 24'h000000;
    end else begin
      rx_q <= {rx_q[22:0], sdi};
    end
  end

  // capture command at cs rise; toggle hands the event to ref_clk
  always_ff @(posedge cs_n or negedge arst_n) begin
    if (!arst_n) begin
      ev_tg_q <= 1'b0;
      ev_hold_q <= 36'h0;
    end else begin
      ev_tg_q <= ~ev_tg_q; // see R8 R9
      ev_hold_q <= {6'h00, bit_cnt_q, rx_q};
    end
  end

  // held word is stable by the time the toggle is seen synchronised;
  // only the second stage onward is read, never the first flop
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ev_word_q <= 36'h0;
    end else if (ev_tg_s3_q ^ ev_tg_s2_q) begin
      ev_word_q <= ev_hold_q;
    end
  end

  wire [5:0] idx = 6'(SHIFT_W - 1) - bit_cnt_q;
  wire in_frame = bit_cnt_q < 6'(SHIFT_W);

  // one selector per lane; both lanes share the bit counter
  logic [SHIFT_W-1:0] lane_img [2];
  logic [1:0] lane_bit;
  assign lane_img[0] = img_a_q;
  assign lane_img[1] = img_b_q;
  for (genvar l = 0; l < 2; l++) begin : g_lane
    assign lane_bit[l] = in_frame ? lane_img[l][idx] : 1'b0;
  end

  assign output_a = lane_bit[0]; // see R7
  assign output_b_alert = lane_bit[1];
  assign output_a_oe = ~cs_n; // see R3 R8
  assign output_b_alert_oe = ~cs_n & ~one_lane;
endmodule

// *** src/dasp_pkg.sv ***
// Purpose: constants for the dual converter serial readout port
// Assumes: register map reduced to two config words plus a status word
// Notes: none
package dasp_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned CONV_TIME_NS = 1000;
  localparam int unsigned CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int unsigned SELFTEST_CYCLES = 16;
  localparam logic [2:0] ADDR_CFG1 = 3'h1;
  localparam logic [2:0] ADDR_CFG2 = 3'h2;
  localparam logic [2:0] ADDR_STAT = 3'h3;
  localparam logic [11:0] CFG1_RESET = 12'h000;
  localparam logic [11:0] CFG2_RESET = 12'h000;
  localparam int unsigned CFG1_OSR_LSB = 5;
  localparam int unsigned CFG1_WCRC = 5'd5 - 5'd1;
  localparam int unsigned CFG1_RCRC = 3;
  localparam int unsigned CFG1_RES = 2;
  localparam int unsigned CFG2_LANE = 0;
  localparam int unsigned CFG2_RST_LSB = 8;
  localparam logic [1:0] RST_HARD = 2'h3;
  localparam int unsigned STAT_SETUP_F = 0;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam int unsigned CMD_BITS = 16;
  localparam int unsigned CMD_CRC_BITS = 24;
  localparam int unsigned SHIFT_W = 44;
endpackage

// *** src/dasp_crc8.sv ***
// Purpose: combinational crc-8 over a 36-bit word, msb first
// Assumes: unused leading bits zero, top byte of read data already inverted by caller; write data passed uninverted
// Notes: polynomial x^8+x^2+x+1, zero initial value
`timescale 1ns/1ps
module dasp_crc8
  import dasp_pkg::*;
(
  input wire logic [35:0] data,
  input wire logic [5:0] nbits,
  output logic [7:0] crc
);
  always_comb begin
    logic [7:0] r;
    logic fb;
    r = 8'h00;
    fb = 1'b0;
    for (int i = 35; i >= 0; i--) begin
      if (i < int'(nbits)) begin
        fb = r[7] ^ data[i];
        r = {r[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
      end
    end
    crc = r;
  end
endmodule

// *** tb/dasp_port_properties.sv ***
// Purpose: port checks for the serial readout port
// Assumes: outputs sampled on ref_clk
// Notes: cs_n is async to ref_clk, so start bounds are loose
`timescale 1ns/1ps
module dasp_port_properties
  import dasp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic selftest_ok,
  input wire logic output_a_oe,
  input wire logic output_b_alert_oe,
  input wire logic conv_start,
  input wire logic conv_busy,
  input wire logic setup_fail_flag,
  input wire logic [11:0] config_word_one,
  input wire logic [11:0] config_word_two
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [9:0] busy_q;
  // restart on a new start so back-to-back frames do not trip the bound
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) busy_q <= '0;
    else busy_q <= (conv_busy && !conv_start) ? busy_q + 10'h1 : 10'h0;
  end
  sequence cs_fall_s; $fell(cs_n); endsequence
  sequence start_s; ##[1:5] conv_start; endsequence
  oe_follow_a: assert property (output_a_oe == !cs_n) else $error("oe a wrong");
  lane_b_oe_a: assert property (output_b_alert_oe == (!cs_n && !config_word_two[CFG2_LANE]))
    else $error("oe b wrong");
  conv_start_a: assert property (cs_fall_s |-> start_s) else $error("no start");
  start_pulse_a: assert property (conv_start |=> !conv_start) else $error("start too long");
  start_busy_a: assert property (conv_start |-> ##[0:2] conv_busy) else $error("not busy");
  busy_bound_a: assert property (busy_q <= CONV_CYCLES + 4) else $error("busy too long");
  fail_cause_a: assert property ($rose(setup_fail_flag) |-> !selftest_ok) else $error("bad fail");
  cfg_quiet_a: assert property ($changed({config_word_one, config_word_two}) |-> cs_n)
    else $error("config moved in frame");
endmodule
bind dasp_port dasp_port_properties chk (.ref_clk, .arst_n, .cs_n, .selftest_ok, .output_a_oe,
  .output_b_alert_oe, .conv_start, .conv_busy, .setup_fail_flag, .config_word_one, .config_word_two);

// *** tb/dasp_host.sv ***
// Purpose: host model that frames serial transfers
// Assumes: sclk idles low and runs only inside a frame
// Notes: data sampled on sclk rise, mid way through each bit
`timescale 1ns/1ps
module dasp_host (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic output_a,
  input wire logic output_b_alert
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // w left aligned, only the first n bits are clocked
  task automatic frame(input logic [43:0] w, input int n, output logic [43:0] qa, output logic [43:0] qb);
    qa = '0;
    qb = '0;
    cs_n = 1'b0;
    #5;
    for (int i = 0; i < n; i++) begin
      sdi = w[43 - i];
      #3 sclk = 1'b1;
      qa = {qa[42:0], output_a};
      qb = {qb[42:0], output_b_alert};
      #3 sclk = 1'b0;
    end
    #3 cs_n = 1'b1;
    sdi = ~sdi;
    #60;
  endtask
endmodule

// *** tb/dual_adc_serial_readout_port_test.sv ***
// Purpose: self-checking bench for the serial readout port
// Assumes: host model owns the link pins
// Notes: waits between frames follow CONV_CYCLES or SELFTEST_CYCLES
`timescale 1ns/1ps
module dual_adc_serial_readout_port_test;
  import dasp_pkg::*;
  logic ref_clk, arst_n, sclk, cs_n, sdi, selftest_ok;
  logic output_a, output_a_oe, output_b_alert, output_b_alert_oe, conv_start, conv_busy, setup_fail_flag;
  logic [17:0] conv_a, conv_b;
  logic [11:0] config_word_one, config_word_two, d;
  logic [43:0] qa, qb, ea, eb;
  logic [17:0] ra, rb;
  logic [35:0] cx;
  int bad_count = 0;
  int cmp_count = 0;
  dasp_port uut (.ref_clk, .arst_n, .sclk, .cs_n, .sdi, .conv_a, .conv_b, .selftest_ok, .output_a,
    .output_a_oe, .output_b_alert, .output_b_alert_oe, .conv_start, .conv_busy, .setup_fail_flag,
    .config_word_one, .config_word_two);
  dasp_host h (.sclk, .cs_n, .sdi, .output_a, .output_b_alert);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] crc8(input logic [35:0] x, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = n - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ x[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction
  task automatic check(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  // write crc always rides behind the command; n decides if it is clocked
  task automatic run(input logic [15:0] c, input int n, input logic [7:0] flip);
    h.frame({c, crc8({20'h0, c}, 16) ^ flip, 20'h0}, n, qa, qb);
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    finish_test;
  end
  initial begin
    arst_n = 1'b0;
    selftest_ok = 1'b1;
    conv_a = '0;
    conv_b = '0;
    void'($urandom(19));
    repeat (12) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (SELFTEST_CYCLES + 8) @(negedge ref_clk);
    check(setup_fail_flag === 1'b0, "self test");
    for (int k = 0; k < 2; k++) begin
      @(negedge ref_clk) selftest_ok = k[0];
      run({1'b1, ADDR_CFG2, 12'h300}, 16, 8'h00);
      repeat (SELFTEST_CYCLES + 8) @(negedge ref_clk);
      check(setup_fail_flag === !k[0] && config_word_two === CFG2_RESET, "hard reset");
    end
    $display("selftest done");
    for (int k = 0; k < 4; k++) begin
      d = 12'($urandom) & 12'h0e7;
      run({1'b1, ADDR_CFG1, d}, 16, 8'h00);
      check(config_word_one === d, "cfg write");
      run({1'b1, 3'h7, ~d}, 16, 8'h00);
      run({1'b0, ADDR_CFG1, 12'h0}, 16, 8'h00);
      run(16'h0000, 16, 8'h00);
      check(qa[15:0] === {1'b0, ADDR_CFG1, d} && config_word_one === d, "cfg read");
    end
    $display("registers done");
    for (int m = 0; m < 8; m++) begin
      run({1'b1, ADDR_CFG2, 11'h0, m[0]}, 16, 8'h00);
      run({1'b1, ADDR_CFG1, 4'h0, 2'b00, m[2], 1'b0, m[1], m[2], 2'b00}, 16, 8'h00);
      repeat (CONV_CYCLES + 10) @(negedge ref_clk);
      conv_a = 18'($urandom);
      conv_b = 18'($urandom);
      run(16'h5000, 16, 8'h00);
      repeat (CONV_CYCLES + 10) @(negedge ref_clk);
      ra = conv_a;
      rb = conv_b;
      conv_a = ~conv_a;
      run(16'h0000, (m[0] ? 32 : 16) + (m[2] ? (m[0] ? 4 : 2) : 0) + (m[1] ? 8 : 0), 8'h00);
      ea = m[0] ? (m[2] ? {8'h0, ra, rb} : {12'h0, ra[17:2], rb[17:2]}) : (m[2] ? {26'h0, ra} : {28'h0, ra[17:2]});
      eb = m[2] ? {26'h0, rb} : {28'h0, rb[17:2]};
      if (m[1]) begin
        cx = m[2] ? {~ra[17:10], ra[9:0], rb} : {4'h0, ~ra[17:10], ra[9:2], rb[17:2]};
        ea = {ea[35:0], crc8(cx, m[2] ? 36 : 32)};
        eb = {eb[35:0], 8'h00};
      end
      check(qa === ea && (m[0] || qb === eb), "conversion data");
    end
    run({1'b1, ADDR_CFG2, 12'h000}, 16, 8'h00);
    $display("conversions done");
    for (int k = 0; k < 6; k++) begin
      run({1'b1, ADDR_CFG1, (k < 3 ? 12'h010 : 12'h000)}, k % 3 ? 24 : 16, 8'(k == 1 || k == 4));
      check(config_word_one[CFG1_WCRC] === (k > 1 && k < 5), "write crc gate");
    end
    $display("write crc done");
    finish_test;
  end
endmodule
